// ### pcve_pkg.sv
/*
 * Constants, register map and carrier types for the pitch correction and
 * volume envelope block. Assumes a 250 MHz system clock and hand streams
 * that are valid whenever the block takes its control sample.
 */
// Overview of operation
// - All twelve semitones corrected identically.
// - Correct only when strength and width non-zero.
// - Strength 0..31 scales pull toward center.
// - Faster speed values; 31 snaps immediately.
// - Slew linearly in log pitch domain.
// - Center modulation speeds centers, slows edges.
// - Loudness modulation bounded by nominal speed.
// - Correct only within capture width of center.
// - Tuner fed pre or post correction.
// - Expander and velocity feed hold, then slew.
// - Expand below knee point; zero defeats.
// - High expansion clamps to zero loudness.
// - Knee point 0..63 spans -48 to 0 dB.
// - Signed hand speed times gain added.
// - Ramp up to hold, then toward hand.
// - Before decay point, reduce release and resonance.
// - Non-zero decay reduction: decay point signals note-off.
// - Decay point compared with raw volume.
// - Duck volume while pitch crosses notes.
// - Attack and release zero pass volume through.
package pcve_pkg;

   // Register map, byte addresses of aligned words.
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] A_PSET = 4'h0;
   localparam logic [ADDR_W-1:0] A_ENV = 4'h4;
   localparam logic [ADDR_W-1:0] A_DYN = 4'h8;
   localparam logic [ADDR_W-1:0] A_STAT = 4'hc;

   // Control sample period and its cycle count.
   localparam int CLK_MHZ = 250;
   localparam int SMP_NS = 4000;
   localparam int SMP_CYC = SMP_NS * CLK_MHZ / 1000;
   localparam int CNT_W = 10;

   // Pitch fraction layout and corrector scaling.
   localparam int FRAC_W = 8;
   localparam logic signed [9:0] CENTER = 10'sh080;
   localparam logic signed [9:0] HALF = 10'sh040;
   localparam logic [9:0] WIN_INC = 10'h004;
   localparam logic [4:0] RATE_SNAP = 5'h1f;
   localparam int DES_SH = 5;
   localparam int MOD_SH = 6;

   // Volume field: one location step is 1024 units, 0.75 dB.
   localparam int LOC_SH = 10;
   localparam logic [LOC_SH-1:0] LOC_ZERO = 10'h000;
   localparam logic [5:0] LOC_TOP = 6'h3f;
   localparam int VEL_SH = 2;
   localparam int DUCK_SH = 3;
   localparam int GAIN_SH = 8;
   localparam logic [8:0] UNITY = 9'h100;
   localparam logic [15:0] VOL_MAX = 16'hffff;

   // Pitch page settings, register A_PSET.
   typedef struct packed {
      logic [4:0] pad;
      logic post;
      logic signed [5:0] vmod;
      logic [4:0] span;
      logic [4:0] cmod;
      logic [4:0] rate;
      logic [4:0] corr;
   } pcve_pset_t;

   // Expander, velocity and duck settings, register A_ENV.
   typedef struct packed {
      logic [10:0] pad;
      logic [4:0] cvol;
      logic [4:0] velo;
      logic [4:0] knee;
      logic [5:0] kloc;
   } pcve_env_t;

   // Ramp and decay settings, register A_DYN.
   typedef struct packed {
      logic [7:0] pad;
      logic [5:0] dloc;
      logic [5:0] damp;
      logic [5:0] fall;
      logic [5:0] rise;
   } pcve_dyn_t;

   // Status word, register A_STAT.
   typedef struct packed {
      logic [13:0] pad;
      logic damp_on;
      logic duck_on;
      logic [15:0] env;
   } pcve_stat_t;

   // One control sample of log pitch and volume position.
   typedef struct packed {
      logic [15:0] pitch;
      logic [15:0] vol;
   } pcve_smp_t;

endpackage

// ### pcve_core.sv
/*
 * Pitch corrector and volume envelope running at the control sample rate.
 * Assumes i_smp is synchronous to i_clk and the register master follows
 * the plain strobe protocol with read data one cycle later.
 */
`timescale 1ns/1ps

module pcve_core (
   input wire logic i_clk, // System clock.
   input wire logic i_nrst, // Asynchronous reset, active low.
   input wire logic [pcve_pkg::ADDR_W-1:0] i_addr, // Register address.
   input wire logic [31:0] i_wdata, // Write data.
   input wire logic i_wr, // Write strobe.
   input wire logic i_rd, // Read strobe.
   output logic [31:0] o_rdata, // Read data, cycle after i_rd.
   input wire pcve_pkg::pcve_smp_t i_smp, // Hand pitch and volume.
   output pcve_pkg::pcve_smp_t o_out, // Corrected pitch, shaped volume.
   output pcve_pkg::pcve_smp_t o_tun, // Tuner pitch and volume.
   output logic [5:0] o_reso_cut, // Resonance reduction.
   output logic o_note_off, // Hand before decay point.
   output logic o_valid // Pulse when outputs update.
);

   ////////////////////////////////////////////////////////////////////////
   // Control sample strobe.

   logic [pcve_pkg::CNT_W-1:0] cnt_ff;
   logic tick;
   assign tick = cnt_ff == pcve_pkg::CNT_W'(pcve_pkg::SMP_CYC - 1);

   // Free running divider; every register still clocks each edge.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= tick ? '0 : cnt_ff + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file: written settings and the active copy.

   pcve_pkg::pcve_pset_t p_ff, ap_ff;
   pcve_pkg::pcve_env_t e_ff, ae_ff;
   pcve_pkg::pcve_dyn_t d_ff, ad_ff;
   pcve_pkg::pcve_stat_t stat;
   logic [31:0] rdata_ff;
   logic [31:0] rd_mux;
   logic wr_p, wr_e, wr_d;

   assign wr_p = i_wr && (i_addr == pcve_pkg::A_PSET);
   assign wr_e = i_wr && (i_addr == pcve_pkg::A_ENV);
   assign wr_d = i_wr && (i_addr == pcve_pkg::A_DYN);

   // Unmapped addresses read as zero.
   assign rd_mux = (i_addr == pcve_pkg::A_PSET) ? 32'(p_ff) :
                   (i_addr == pcve_pkg::A_ENV) ? 32'(e_ff) :
                   (i_addr == pcve_pkg::A_DYN) ? 32'(d_ff) :
                   (i_addr == pcve_pkg::A_STAT) ? 32'(stat) : 32'h0;

   // Writes land in staging; the active copy moves only on a sample so
   // the datapath never sees half of a settings change.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         p_ff <= '0;
         e_ff <= '0;
         d_ff <= '0;
         ap_ff <= '0;
         ae_ff <= '0;
         ad_ff <= '0;
         rdata_ff <= '0;
      end else begin
         if (wr_p) p_ff <= pcve_pkg::pcve_pset_t'(i_wdata);
         if (wr_e) e_ff <= pcve_pkg::pcve_env_t'(i_wdata);
         if (wr_d) d_ff <= pcve_pkg::pcve_dyn_t'(i_wdata);
         if (tick) begin
            ap_ff <= p_ff;
            ae_ff <= e_ff;
            ad_ff <= d_ff;
         end
         rdata_ff <= i_rd ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pitch error; only the fraction matters, so every semitone is alike.

   logic signed [9:0] err;
   logic [9:0] abs_e;
   logic [9:0] win;
   logic en;
   assign err = $signed({2'h0, i_smp.pitch[pcve_pkg::FRAC_W-1:0]})
                - pcve_pkg::CENTER;
   assign abs_e = err[9] ? 10'(-err) : err;
   assign win = {3'h0, ap_ff.span, 2'h0} + pcve_pkg::WIN_INC;
   assign en = (ap_ff.corr != 5'h00) && (ap_ff.span != 5'h00)
               && (abs_e <= win);

   // Target offset scales the error by strength; 31 cancels it fully.
   logic [5:0] corr1;
   logic signed [16:0] dprod;
   logic signed [9:0] des;
   assign corr1 = {1'b0, ap_ff.corr} + 6'h01;
   assign dprod = $signed({{7{err[9]}}, err})
                  * $signed({11'h000, corr1});
   assign des = 10'(-(dprod >>> pcve_pkg::DES_SH));

   // Speed: nominal rate, plus center nearness, less quiet-hand term.
   logic signed [9:0] cdev;
   logic signed [15:0] cprod, vprod;
   logic [6:0] vquiet;
   logic signed [11:0] spd;
   logic [4:0] step;
   assign cdev = pcve_pkg::HALF - $signed(abs_e);
   assign cprod = $signed({11'h000, ap_ff.cmod})
                  * $signed({{6{cdev[9]}}, cdev});
   assign vquiet = {1'b0, pcve_pkg::LOC_TOP
                   - i_smp.vol[15:pcve_pkg::LOC_SH]};
   assign vprod = $signed({{10{ap_ff.vmod[5]}}, ap_ff.vmod})
                  * $signed({9'h000, vquiet});
   assign spd = $signed({7'h00, ap_ff.rate})
                + 12'(cprod >>> pcve_pkg::MOD_SH)
                - 12'(vprod >>> pcve_pkg::MOD_SH);
   assign step = spd[11] ? 5'h00 : (spd > 12'sh01f) ? 5'h1f : spd[4:0];

   // Constant-step slew in the log domain; full rate snaps at once.
   logic signed [9:0] off_ff, nxt_off;
   logic signed [10:0] diff;
   logic [10:0] adiff;
   assign diff = {des[9], des} - {off_ff[9], off_ff};
   assign adiff = diff[10] ? 11'(-diff) : diff;
   assign nxt_off = !en ? 10'sh000 :
                    (ap_ff.rate == pcve_pkg::RATE_SNAP) ? des :
                    (adiff <= {6'h00, step}) ? des :
                    diff[10] ? off_ff - $signed({5'h00, step}) :
                    off_ff + $signed({5'h00, step});
   logic [15:0] pitch_out;
   assign pitch_out = i_smp.pitch + {{6{nxt_off[9]}}, nxt_off};

   ////////////////////////////////////////////////////////////////////////
   // Knee expander and velocity detector in parallel.

   logic [15:0] v, kpos, kdiff, vk;
   logic [21:0] kexp;
   logic below;
   assign v = i_smp.vol;
   assign kpos = {ae_ff.kloc, pcve_pkg::LOC_ZERO};
   assign below = v < kpos;
   assign kdiff = kpos - v;
   assign kexp = kdiff * ({1'b0, ae_ff.knee} + 6'h01);
   assign vk = !below ? v :
               (kexp >= {6'h00, kpos}) ? 16'h0000 :
               kpos - kexp[15:0];

   logic [15:0] vprev_ff;
   logic signed [16:0] dv;
   logic signed [22:0] velp, vel;
   logic [23:0] sum;
   logic [15:0] pre;
   assign dv = $signed({1'b0, v}) - $signed({1'b0, vprev_ff});
   assign velp = dv * $signed({1'b0, ae_ff.velo});
   assign vel = velp >>> pcve_pkg::VEL_SH;
   assign sum = {8'h00, vk} + {vel[22], vel};
   assign pre = sum[23] ? 16'h0000 :
                (|sum[22:16]) ? pcve_pkg::VOL_MAX : sum[15:0];

   ////////////////////////////////////////////////////////////////////////
   // Peak hold and ramp; the decay point is judged on raw volume.

   logic damp_act;
   logic [5:0] fall_eff;
   assign damp_act = (ad_ff.damp != 6'h00)
                     && (v < {ad_ff.dloc, pcve_pkg::LOC_ZERO});
   assign fall_eff = !damp_act ? ad_ff.fall :
                     (ad_ff.fall > ad_ff.damp) ?
                     ad_ff.fall - ad_ff.damp : 6'h00;

   logic [15:0] env_ff, hold_ff, nxt_env, nxt_hold;
   logic [15:0] up, dn, dgap, env_up, env_dn;
   logic [16:0] nup, dn1;
   logic bypass;
   assign bypass = (ad_ff.rise == 6'h00) && (ad_ff.fall == 6'h00);
   assign up = (hold_ff - env_ff) >> ad_ff.rise[5:2];
   assign nup = {1'b0, env_ff} + {1'b0, up} + 17'h00001;
   assign env_up = (nup > {1'b0, hold_ff}) ? hold_ff : nup[15:0];
   assign dgap = env_ff - hold_ff;
   assign dn = dgap >> fall_eff[5:2];
   assign dn1 = {1'b0, dn} + 17'h00001;
   assign env_dn = (dn1 >= {1'b0, dgap}) ? hold_ff : env_ff - dn1[15:0];

   // Rise chases the hold; once reached the hold drops to the hand.
   assign nxt_env = bypass ? pre :
                    (env_ff < hold_ff) ? env_up : env_dn;
   assign nxt_hold = ((pre >= hold_ff) || (env_ff >= hold_ff)) ?
                     pre : hold_ff;

   ////////////////////////////////////////////////////////////////////////
   // Transition duck: gain falls as the pitch hand nears a note edge.

   logic [9:0] over;
   logic [11:0] dprd;
   logic [8:0] gain;
   logic [24:0] volp;
   logic [15:0] vol_out;
   assign over = (abs_e > pcve_pkg::HALF) ?
                 abs_e - pcve_pkg::HALF : 10'h000;
   assign dprd = ae_ff.cvol * over[6:0];
   assign gain = pcve_pkg::UNITY
                 - {1'b0, 8'(dprd >> pcve_pkg::DUCK_SH)};
   assign volp = nxt_env * gain;
   assign vol_out = 16'(volp >> pcve_pkg::GAIN_SH);

   ////////////////////////////////////////////////////////////////////////
   // Sample-rate state and registered outputs.

   pcve_pkg::pcve_smp_t out_ff, tun_ff;
   logic [5:0] reso_ff;
   logic noff_ff, duck_ff, valid_ff;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         off_ff <= '0;
         env_ff <= '0;
         hold_ff <= '0;
         vprev_ff <= '0;
         out_ff <= '0;
         tun_ff <= '0;
         reso_ff <= '0;
         noff_ff <= 1'b0;
         duck_ff <= 1'b0;
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= tick;
         if (tick) begin
            off_ff <= nxt_off;
            env_ff <= nxt_env;
            hold_ff <= nxt_hold;
            vprev_ff <= v;
            out_ff <= '{pitch: pitch_out, vol: vol_out};
            tun_ff.pitch <= ap_ff.post ? pitch_out : i_smp.pitch;
            tun_ff.vol <= ap_ff.post ? vol_out : pre;
            reso_ff <= damp_act ? ad_ff.damp : 6'h00;
            noff_ff <= damp_act;
            duck_ff <= gain != pcve_pkg::UNITY;
         end
      end
   end

   assign stat = '{pad: '0, damp_on: noff_ff, duck_on: duck_ff,
                   env: env_ff};
   assign o_rdata = rdata_ff;
   assign o_out = out_ff;
   assign o_tun = tun_ff;
   assign o_reso_cut = reso_ff;
   assign o_note_off = noff_ff;
   assign o_valid = valid_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks. Except a_hold, they look one cycle after the tick (a_noff also at o_valid one cycle later), at the registered outputs, or at env_ff and
   // duck_ff for a_envpass, a_rise and a_noduck; the outputs are where the voice and the tuner see them.

   property p_bypass;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && (ap_ff.corr == 5'h00) |=> o_out.pitch == $past(i_smp.pitch);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("Pitch changed with correction off.");

   property p_span;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && (abs_e > win) |=> o_out.pitch == $past(i_smp.pitch);
   endproperty
   a_span: assert property (p_span)
      else $error("Pitch corrected outside capture width.");

   property p_snap;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && en && (ap_ff.rate == pcve_pkg::RATE_SNAP)
         && (ap_ff.corr == 5'h1f)
      |=> o_out.pitch[7:0] == 8'h80;
   endproperty
   a_snap: assert property (p_snap)
      else $error("Full rate did not snap to note center.");

   property p_envpass;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && bypass |=> env_ff == $past(pre);
   endproperty
   a_envpass: assert property (p_envpass)
      else $error("Envelope altered volume with zero ramps.");

   property p_rise;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && !bypass && (env_ff < hold_ff)
      |=> (env_ff > $past(env_ff)) && (env_ff <= $past(hold_ff));
   endproperty
   a_rise: assert property (p_rise)
      else $error("Rise did not move toward the hold.");

   property p_knee0;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && bypass && (ae_ff.knee == 5'h00) && (ae_ff.velo == 5'h00)
         && (ae_ff.cvol == 5'h00)
      |=> o_out.vol == $past(i_smp.vol);
   endproperty
   a_knee0: assert property (p_knee0)
      else $error("Volume changed with shaping defeated.");

   property p_post;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && !ap_ff.post |=> o_tun.pitch == $past(i_smp.pitch);
   endproperty
   a_post: assert property (p_post)
      else $error("Tuner not fed pre-correction pitch.");

   property p_damp;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && damp_act |=> o_reso_cut == $past(ad_ff.damp) && o_note_off;
   endproperty
   a_damp: assert property (p_damp)
      else $error("Decay reduction missing before decay point.");

   property p_noff;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && (ad_ff.damp == 6'h00) |=> !o_note_off ##1 !o_valid;
   endproperty
   a_noff: assert property (p_noff)
      else $error("Note-off flagged with decay reduction zero.");

   property p_hold;
      @(posedge i_clk) disable iff (!i_nrst)
      !tick |=> $stable(ap_ff) && $stable(ad_ff) && $stable(ae_ff);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Active settings changed between samples.");

   property p_noduck;
      @(posedge i_clk) disable iff (!i_nrst)
      tick && (ae_ff.cvol == 5'h00) |=> !duck_ff;
   endproperty
   a_noduck: assert property (p_noduck)
      else $error("Volume ducked with duck setting zero.");

endmodule

// ### pcve_src.sv
/*
 * Model of the upstream field processing that feeds hand samples.
 * Assumes the bench asks for a new sample well away from the tick.
 */
`timescale 1ns/1ps

module pcve_src (
   input wire logic i_clk, // System clock.
   input wire logic i_nrst, // Asynchronous reset, active low.
   input wire logic i_load, // Take a new sample.
   input wire pcve_pkg::pcve_smp_t i_next, // Sample to present.
   output pcve_pkg::pcve_smp_t o_smp // Held hand sample.
);

   // The field filters settle slowly, so a sample is held between loads.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_smp <= '0;
      end else if (i_load) begin
         o_smp <= i_next;
      end
   end

endmodule

// ### tb_top.sv
/*
 * Self-checking bench for the pitch corrector and volume envelope.
 * Assumes pcve_core and pcve_src are compiled first.
 */
`timescale 1ns/1ps

module tb_top;
   logic i_clk, i_nrst, i_wr, i_rd, ld;
   logic [pcve_pkg::ADDR_W-1:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d, r;
   pcve_pkg::pcve_smp_t i_smp, o_out, o_tun, nxt;
   logic [5:0] o_reso_cut;
   logic o_note_off, o_valid, hit;
   logic [15:0] p, v, ep, ev;
   pcve_pkg::pcve_pset_t ps;
   pcve_pkg::pcve_env_t es;
   pcve_pkg::pcve_dyn_t ds;
   int mismatches, num_checks, cyc, seed, i, pre, st;
   int steps[3] = '{2, 13, 0};

   pcve_core DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_smp(i_smp), .o_out(o_out), .o_tun(o_tun),
      .o_reso_cut(o_reso_cut), .o_note_off(o_note_off), .o_valid(o_valid));

   pcve_src SRC (.i_clk(i_clk), .i_nrst(i_nrst), .i_load(ld),
      .i_next(nxt), .o_smp(i_smp));

   ////////////////////////////////////////////////////////////////////////
   // Expected pitch: snap offset inside the capture window only.
   function automatic logic [15:0] exp_pitch(logic [15:0] pt, int c, int s);
      int err, a, off;
      err = pt[7:0] - 128;
      a = (err < 0) ? -err : err;
      off = 0;
      if (c != 0 && s != 0 && a <= s * 4 + 4) begin
         off = -((err * (c + 1)) >>> 5);
      end
      return pt + off[15:0];
   endfunction

   // Expected volume before the envelope: knee plus velocity, clamped.
   function automatic int exp_pre(int vol, int pv, int kl, int kn, int ve);
      int kpos, vk;
      kpos = kl << 10;
      vk = vol;
      if (vol < kpos) begin
         vk = kpos - (kpos - vol) * (kn + 1);
         if (vk < 0) vk = 0;
      end
      vk = vk + (((vol - pv) * ve) >>> 2);
      return (vk < 0) ? 0 : ((vk > 65535) ? 65535 : vk);
   endfunction

   // Expected output volume after the transition duck.
   function automatic logic [15:0] exp_vol(int pr, logic [15:0] pt, int cv);
      int a, g;
      a = pt[7:0] - 128;
      a = (a < 0) ? -a : a;
      g = 256 - ((cv * ((a > 64) ? a - 64 : 0)) >>> 3);
      return 16'((pr * g) >>> 8);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Shared comparison, bus and sample tasks.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] dat);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= dat;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] dat);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 dat = o_rdata;
   endtask

   task automatic cfg();
      wr(pcve_pkg::A_PSET, ps);
      wr(pcve_pkg::A_ENV, es);
      wr(pcve_pkg::A_DYN, ds);
   endtask

   task automatic put(input logic [15:0] pt, input logic [15:0] vo);
      @(posedge i_clk);
      nxt <= {pt, vo};
      ld <= 1'b1;
      @(posedge i_clk);
      ld <= 1'b0;
   endtask

   // Waiting at the falling edge keeps clear of the update edge.
   task automatic tick(input int n);
      int k;
      repeat (n) begin
         k = 0;
         @(negedge i_clk);
         while (o_valid !== 1'b1 && k < 1200) begin
            k++;
            @(negedge i_clk);
         end
         if (k >= 1200) begin
            mismatches++;
            $display("BAD %0t no output update", $time);
         end
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the whole run needs about 59000 cycles.
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         mismatches++;
         print_verdict();
      end
   end

   // Main sequence.
   initial begin
      i_nrst = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = '0; i_wdata = '0;
      ld = 1'b0; nxt = '0; ps = '0; es = '0; ds = '0; cyc = 0; seed = 259;
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd(pcve_pkg::A_DYN, d);
      chk(d, 32'h0);
      ps = $random(seed); ps.pad = '0;
      es = $random(seed); es.pad = '0;
      ds = $random(seed); ds.pad = '0;
      cfg();
      rd(pcve_pkg::A_PSET, d);
      chk(d, ps);
      rd(pcve_pkg::A_ENV, d);
      chk(d, es);
      rd(pcve_pkg::A_DYN, d);
      chk(d, ds);
      rd(4'h2, d);
      chk(d, 32'h0);
      $display("register test done");
      // A new setting must not act on the sample that copies it.
      ps = '0; es = '0; ds = '0;
      cfg();
      put(16'h05c0, 16'h8000);
      tick(2);
      chk(o_out.pitch, 16'h05c0);
      chk(o_out.vol, 16'h8000);
      ps.corr = 5'h1f; ps.span = 5'h1f; ps.rate = 5'h1f;
      cfg();
      tick(1);
      chk(o_out.pitch, 16'h05c0);
      tick(1);
      chk(o_out.pitch, exp_pitch(16'h05c0, 31, 31));
      $display("staging test done");
      // Random snap settings with corner cases at the first iterations.
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         ps = '0; ps.rate = 5'h1f; ps.corr = r[4:0]; ps.span = r[9:5];
         ps.cmod = r[14:10]; ps.vmod = r[20:15]; ps.post = r[21];
         if (i == 0) ps.corr = '0;
         if (i == 1) ps.span = '0;
         r = $random(seed);
         es = '0; es.kloc = r[5:0]; es.knee = r[10:6];
         es.velo = r[15:11]; es.cvol = r[20:16];
         if (i == 2) es.knee = 5'h1f;
         r = $random(seed);
         ds = '0; ds.damp = r[5:0]; ds.dloc = r[11:6];
         if (i == 4) ds.damp = '0;
         r = $random(seed);
         p = r[15:0];
         v = (i == 3) ? {ds.dloc, 10'h000} - 16'h1 : r[31:16];
         if (i == 5) v = {ds.dloc, 10'h000};
         cfg();
         put(p, v);
         tick(2);
         ep = exp_pitch(p, ps.corr, ps.span);
         pre = exp_pre(v, v, es.kloc, es.knee, 0);
         ev = exp_vol(pre, p, es.cvol);
         chk(o_out.pitch, ep);
         chk(o_out.vol, ev);
         chk(o_tun, ps.post ? {ep, ev} : {p, 16'(pre)});
         hit = (ds.damp != 0) && (v < {ds.dloc, 10'h000});
         chk(o_note_off, hit);
         chk(o_reso_cut, hit ? ds.damp : 6'h00);
      end
      $display("random test done");
      // Hand speed in both directions.
      ps = '0; es = '0; es.velo = 5'h08; ds = '0;
      cfg();
      put(16'h0480, 16'd20000);
      tick(2);
      put(16'h0480, 16'd30000);
      tick(1);
      chk(o_out.vol, exp_pre(30000, 20000, 0, 0, 8));
      put(16'h0480, 16'd10000);
      tick(1);
      chk(o_tun.vol, exp_pre(10000, 30000, 0, 0, 8));
      $display("velocity test done");
      // Slew steps: plain, centre boosted, and held back at low volume.
      es = '0;
      for (i = 0; i < 3; i++) begin
         ps = '0; ps.rate = 5'h02; ps.span = 5'h1f;
         cfg();
         put(16'h0da8, 16'h0000);
         tick(2);
         ps.corr = 5'h1f; ps.cmod = (i == 1) ? 5'h1f : 5'h00;
         ps.vmod = (i == 2) ? 6'sh1f : 6'sh00;
         cfg();
         tick(2);
         st = steps[i];
         chk(o_out.pitch, 16'(16'h0da8 - st));
         tick(1);
         chk(o_out.pitch, 16'(16'h0da8 - 2 * st));
      end
      $display("slew test done");
      // Envelope ramps up to the held peak, then falls toward the hand.
      ps = '0; ds.rise = 6'h04; ds.fall = 6'h04;
      cfg();
      put(16'h0480, 16'h0000);
      tick(2);
      put(16'h0480, 16'd40000);
      // The hold takes the new peak one sample before the ramp moves.
      tick(2);
      chk(o_out.vol > 0 && o_out.vol < 16'd40000, 1);
      hit = 1'b0;
      for (i = 0; i < 18 && !hit; i++) begin
         tick(1);
         hit = (o_out.vol === 16'd40000);
      end
      chk(hit, 1);
      put(16'h0480, 16'h0000);
      tick(2);
      chk(o_out.vol > 0 && o_out.vol < 16'd40000, 1);
      rd(pcve_pkg::A_STAT, d);
      chk(d, 32'(40000 - (40000 >> 1) - 1));
      $display("envelope test done");
      print_verdict();
   end

endmodule
